// >>> verif/btm_host_model.sv
`timescale 1ns/1ps

module btm_host_model (
	input wire logic clk_in,
	input wire logic sdo_in,
	output logic sclk_out,
	output logic chip_select_low_active_out,
	output logic sdi_out
);
	initial begin
		sclk_out = 1'b0;
		chip_select_low_active_out = 1'b1;
		sdi_out = 1'b0;
	end

	// One frame of nbits bits, LSB first; each serial clock high phase lasts five system cycles, each low phase nine.
	// The device shifts on the falling edge, so its bit k is taken just before rise k.
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk_in);
		chip_select_low_active_out = 1'b0;
		for (int k = 0; k < nbits; k++) begin
			sdi_out = tx[k];
			repeat (5) @(negedge clk_in);
			rx[k] = sdo_in;
			sclk_out = 1'b1;
			repeat (5) @(negedge clk_in);
			sclk_out = 1'b0;
			repeat (4) @(negedge clk_in);
		end
		@(negedge clk_in);
		chip_select_low_active_out = 1'b1;
		// A released data line must not look held, so it shows the inverse of its last bit.
		sdi_out = ~sdi_out;
		repeat (8) @(negedge clk_in);
	endtask
endmodule

// >>> verif/btm_mode_regs_checker.sv
`timescale 1ns/1ps

module btm_mode_regs_checker (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire btm_pkg::btm_chip_mode_e chip_mode_in,
	input wire logic system_error_flag_in,
	input wire logic soft_reset_in,
	input wire logic lin_flash_out,
	input wire logic low_slope_bit_out,
	input wire logic transmit_timeout_control_bit_out,
	input wire btm_pkg::btm_xcvr_mode_e lin_mode_out,
	input wire btm_pkg::btm_xcvr_mode_e can_mode_out,
	input wire logic selective_wake_out,
	input wire logic peak_threshold_bit_out
);
	import btm_pkg::*;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	////////////////////////////////////////////////////////////////////////////
	sequence sleep_entry_s;
		chip_mode_in == BTM_CHIP_SLEEP && $past(chip_mode_in) != BTM_CHIP_SLEEP;
	endsequence
	sequence stop_entry_s;
		chip_mode_in == BTM_CHIP_STOP && $past(chip_mode_in) != BTM_CHIP_STOP;
	endsequence
	sequence fail_entry_s;
		chip_mode_in == BTM_CHIP_FAILSAFE && $past(chip_mode_in) != BTM_CHIP_FAILSAFE;
	endsequence
	sequence stop_hold_s;
		(chip_mode_in == BTM_CHIP_STOP) ##1 (chip_mode_in == BTM_CHIP_STOP);
	endsequence

	////////////////////////////////////////////////////////////////////////////
	// Event updates land one cycle after the entry edge; two are allowed for soft reset, three for mode entries.
	a_soft_reset_vals: assert property (soft_reset_in |-> ##[1:2]
		(transmit_timeout_control_bit_out && !lin_flash_out && !low_slope_bit_out &&
		lin_mode_out == BTM_XCVR_OFF && can_mode_out == BTM_XCVR_OFF && !peak_threshold_bit_out))
		else $error("soft reset values wrong");
	a_sel_wake_gated: assert property (selective_wake_out |-> can_mode_out != BTM_XCVR_OFF)
		else $error("selective wake with CAN off");
	a_sel_wake_kept: assert property (sleep_entry_s |=> $stable(selective_wake_out)[*3])
		else $error("selective wake changed on sleep");
	a_sleep_normal_wake: assert property (sleep_entry_s ##0
		(can_mode_out == BTM_XCVR_NORMAL && !system_error_flag_in) |-> ##[1:3]
		can_mode_out == BTM_XCVR_WAKE) else $error("normal CAN not made wake capable");
	a_sleep_rx_wake: assert property (sleep_entry_s ##0 can_mode_out == BTM_XCVR_RX_ONLY
		|-> ##[1:3] can_mode_out == BTM_XCVR_WAKE) else $error("receive only kept on sleep");
	a_stop_keeps_can: assert property (stop_entry_s |=> $stable(can_mode_out)[*3])
		else $error("CAN mode changed on stop");
	a_low_power_keep: assert property ((sleep_entry_s or stop_entry_s) ##0
		(can_mode_out inside {BTM_XCVR_OFF, BTM_XCVR_WAKE}) |=> $stable(can_mode_out)[*3])
		else $error("wake or off CAN mode changed");
	a_failsafe_force: assert property (fail_entry_s |-> ##[1:3] (lin_mode_out == BTM_XCVR_WAKE
		&& can_mode_out == BTM_XCVR_WAKE && !selective_wake_out))
		else $error("fail-safe modes not forced");
	a_failsafe_upper: assert property (fail_entry_s |=>
		$stable({lin_flash_out, low_slope_bit_out, transmit_timeout_control_bit_out})[*3])
		else $error("fail-safe changed upper bits");
	a_peak_stop_ro: assert property (stop_hold_s |-> $stable(peak_threshold_bit_out))
		else $error("peak bit changed in stop");
endmodule

bind btm_mode_regs btm_mode_regs_checker btm_mode_regs_checker_inst (
	.clk_in(clk_in),
	.resetn_in(resetn_in),
	.chip_mode_in(chip_mode_in),
	.system_error_flag_in(system_error_flag_in),
	.soft_reset_in(soft_reset_in),
	.lin_flash_out(lin_flash_out),
	.low_slope_bit_out(low_slope_bit_out),
	.transmit_timeout_control_bit_out(transmit_timeout_control_bit_out),
	.lin_mode_out(lin_mode_out),
	.can_mode_out(can_mode_out),
	.selective_wake_out(selective_wake_out),
	.peak_threshold_bit_out(peak_threshold_bit_out)
);

// >>> verif/btm_mode_regs_tb.sv
`timescale 1ns/1ps

module btm_mode_regs_tb;
	import btm_pkg::*;
	logic clk, rst_n, sclk, cs_low_active, sdi, sys_err, soft_rst;
	logic sdo, sdo_oe_n, flash, slope, timeout, sel_wake, peak, ser_err;
	logic [1:0] rs_lin, rs_can;
	btm_chip_mode_e cmode;
	btm_xcvr_mode_e lin_m, can_m;
	int num_errors = 0;
	int cmp_count = 0;
	int err_pulses = 0;
	int n;
	logic [7:0] v;
	logic oe_seen = 1'b0;
	logic [15:0] rx;
	logic [7:0] corner [4] = '{8'hC3, 8'h04, 8'hFF, 8'h00};

	btm_mode_regs btm_mode_regs_inst (.clk_in(clk), .resetn_in(rst_n), .sclk_in(sclk),
		.chip_select_low_active_in(cs_low_active), .sdi_in(sdi), .chip_mode_in(cmode),
		.system_error_flag_in(sys_err), .soft_reset_in(soft_rst), .restart_lin_mode_in(rs_lin),
		.restart_can_mode_in(rs_can), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
		.lin_flash_out(flash), .low_slope_bit_out(slope),
		.transmit_timeout_control_bit_out(timeout), .lin_mode_out(lin_m), .can_mode_out(can_m),
		.selective_wake_out(sel_wake), .peak_threshold_bit_out(peak),
		.serial_error_set_out(ser_err));
	btm_host_model btm_host_model_inst (.clk_in(clk), .sdo_in(sdo), .sclk_out(sclk),
		.chip_select_low_active_out(cs_low_active), .sdi_out(sdi));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (ser_err === 1'b1) err_pulses++;
	always @(posedge clk) if (sdo_oe_n === 1'b0) oe_seen <= 1'b1;

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		btm_host_model_inst.xfer({d, a, 1'b1}, 16, rx);
	endtask
	task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
		btm_host_model_inst.xfer({8'h00, a, 1'b0}, 16, rx);
		chk("register", rx[15:8], exp);
	endtask
	task automatic chk_outs(input logic [7:0] x);
		chk("outputs", {flash, slope, timeout, lin_m, sel_wake, can_m},
			{x[7:3], x[2] && x[1:0] != 2'b00, x[1:0]});
	endtask
	task automatic go(input btm_chip_mode_e m);
		@(negedge clk);
		cmode = m;
		repeat (4) @(negedge clk);
	endtask
	function automatic logic [7:0] sleep_exp(input logic [7:0] x, input logic se);
		if (x[1:0] == 2'b10 || (x[1:0] == 2'b11 && !se)) x[1:0] = 2'b01;
		return x;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		print_verdict();
	end

	initial begin
		rst_n = 1'b0;
		cmode = BTM_CHIP_INIT;
		sys_err = 1'b0;
		soft_rst = 1'b0;
		rs_lin = 2'b00;
		rs_can = 2'b00;
		void'($urandom(89));
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		chk_outs(8'h20);
		chk_reg(7'h04, 8'h20);
		chk_reg(7'h05, 8'h00);
		wr(7'h05, 8'hFF);
		chk_reg(7'h05, 8'h20);
		chk("peak", {7'h00, peak}, 8'h01);
		go(BTM_CHIP_NORMAL);
		wr(7'h05, 8'h00);
		chk("peak", {7'h00, peak}, 8'h00);
		wr(7'h06, 8'hFF);
		chk_reg(7'h06, 8'h00);
		for (int i = 0; i < 12; i++) begin
			v = (i < 4) ? corner[i] : 8'($urandom);
			wr(7'h04, v);
			chk_outs(v);
			chk_reg(7'h04, v);
		end
		for (int i = 0; i < 8; i++) begin
			v = {3'($urandom), 2'($urandom), 1'b1, i[1:0]};
			sys_err = i[2];
			wr(7'h04, v);
			go(BTM_CHIP_SLEEP);
			chk_reg(7'h04, sleep_exp(v, i[2]));
			go(BTM_CHIP_NORMAL);
		end
		sys_err = 1'b0;
		// The host picks receive only itself before stop; stop entry leaves the CAN mode unchanged.
		v = 8'h1E;
		wr(7'h04, v);
		go(BTM_CHIP_STOP);
		n = err_pulses;
		wr(7'h05, 8'h20);
		chk_reg(7'h05, 8'h00);
		chk("error pulses", 8'(err_pulses), 8'(n));
		chk_outs(v);
		go(BTM_CHIP_NORMAL);
		// A frame cut after eight bits must flag an error and leave the register alone.
		n = err_pulses;
		btm_host_model_inst.xfer({8'h00, 7'h04, 1'b1}, 8, rx);
		chk("error pulses", 8'(err_pulses), 8'(n + 1));
		chk_reg(7'h04, v);
		chk("sdo enable", {6'h00, oe_seen, sdo_oe_n}, 8'h03);
		wr(7'h04, 8'hE7);
		wr(7'h05, 8'h20);
		rs_lin = 2'b10;
		rs_can = 2'b01;
		go(BTM_CHIP_RESTART);
		chk_reg(7'h04, 8'hF5);
		chk_reg(7'h05, 8'h20);
		go(BTM_CHIP_NORMAL);
		wr(7'h04, 8'hFF);
		go(BTM_CHIP_FAILSAFE);
		chk_reg(7'h04, 8'hE9);
		go(BTM_CHIP_NORMAL);
		soft_rst = 1'b1;
		@(negedge clk);
		soft_rst = 1'b0;
		repeat (2) @(negedge clk);
		chk_reg(7'h04, 8'h20);
		chk_reg(7'h05, 8'h00);
		print_verdict();
	end
endmodule

// >>> verilog/btm_frame_if.sv
`timescale 1ns/1ps

interface btm_frame_if;
	logic [6:0] addr;
	logic wr;
	logic [7:0] data;
	logic addr_ready;
	logic frame_done;
	logic frame_bad;
	logic [7:0] rd_data;
	logic sdo;
	logic sdo_oe_n;

	modport rx (
		output addr,
		output wr,
		output data,
		output addr_ready,
		output frame_done,
		output frame_bad,
		output sdo,
		output sdo_oe_n,
		input rd_data
	);

	modport regs (
		input addr,
		input wr,
		input data,
		input addr_ready,
		input frame_done,
		input frame_bad,
		input sdo,
		input sdo_oe_n,
		output rd_data
	);
endinterface

// >>> verilog/btm_mode_regs.sv
// Behaviour
// - Mode register at 0x04, resets to 0x20
// - Restart keeps top three bits, reloads modes
// - Flash bit set disables LIN slope control
// - Low-slope bit selects slow LIN mode
// - Timeout control bit enables transmit supervision
// - LIN field: off, wake, receive, normal
// - CAN field: low bits mode, top selective wake
// - Device alters the selective wake bit only on soft reset and fail-safe entry
// - Slope bits act when chip select rises
// - Sleep without system error: normal becomes wake
// - Receive-only: wake on sleep, kept on stop
// - Wake or off modes stay unchanged
// - Fail-safe entry forces low bits 0 1001
// - Peak register at 0x05, restart keeps bit 5
// - Bit 5 selects higher regulator peak threshold
// - Peak bit writable only in init, normal
// - Refused stop-mode peak write raises no error
// - Reserved peak register bits read zero
`timescale 1ns/1ps
`include "btm_params.svh"

module btm_mode_regs (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic sclk_in,
	input wire logic chip_select_low_active_in,
	input wire logic sdi_in,
	input wire btm_pkg::btm_chip_mode_e chip_mode_in,
	input wire logic system_error_flag_in,
	input wire logic soft_reset_in,
	input wire logic [1:0] restart_lin_mode_in,
	input wire logic [1:0] restart_can_mode_in,
	output logic sdo_out,
	output logic sdo_oe_n_out,
	output logic lin_flash_out,
	output logic low_slope_bit_out,
	output logic transmit_timeout_control_bit_out,
	output btm_pkg::btm_xcvr_mode_e lin_mode_out,
	output btm_pkg::btm_xcvr_mode_e can_mode_out,
	output logic selective_wake_out,
	output logic peak_threshold_bit_out,
	output logic serial_error_set_out
);
	import btm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	// The pins are asynchronous to clk_in, so each passes two flip-flops.
	// Serial clock edges are found by comparing the second stage with a third,
	// which keeps the first stage free of any other reader.
	logic [1:0] sclk_sync_ff, nxt_sclk_sync;
	logic [1:0] cs_sync_ff, nxt_cs_sync;
	logic [1:0] sdi_sync_ff, nxt_sdi_sync;
	logic sclk_last_ff, nxt_sclk_last;
	logic cs_last_ff, nxt_cs_last;

	always_comb begin
		nxt_sclk_sync = {sclk_sync_ff[0], sclk_in};
		nxt_cs_sync = {cs_sync_ff[0], chip_select_low_active_in};
		nxt_sdi_sync = {sdi_sync_ff[0], sdi_in};
		nxt_sclk_last = sclk_sync_ff[1];
		nxt_cs_last = cs_sync_ff[1];
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sclk_sync_ff <= 2'h0;
			cs_sync_ff <= 2'h3;
			sdi_sync_ff <= 2'h0;
			sclk_last_ff <= 1'b0;
			cs_last_ff <= 1'b1;
		end else begin
			sclk_sync_ff <= nxt_sclk_sync;
			cs_sync_ff <= nxt_cs_sync;
			sdi_sync_ff <= nxt_sdi_sync;
			sclk_last_ff <= nxt_sclk_last;
			cs_last_ff <= nxt_cs_last;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_active;
	logic cs_start;
	logic cs_end;

	assign sclk_rise = sclk_sync_ff[1] & ~sclk_last_ff;
	assign sclk_fall = ~sclk_sync_ff[1] & sclk_last_ff;
	assign cs_active = ~cs_sync_ff[1];
	assign cs_start = ~cs_sync_ff[1] & cs_last_ff;
	assign cs_end = cs_sync_ff[1] & ~cs_last_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Serial frame handling.

	btm_frame_if frame ();

	btm_spi_frame #(
		.FRAME_BITS(`BTM_FRAME_BITS)
	) u_frame (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.sclk_rise_in(sclk_rise),
		.sclk_fall_in(sclk_fall),
		.cs_active_in(cs_active),
		.cs_start_in(cs_start),
		.cs_end_in(cs_end),
		.sdi_in(sdi_sync_ff[1]),
		.bus(frame.rx)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// CAN low bits after sleep entry; stop entry never reaches here, so a
	// receive-only setting made by the host survives stop mode.
	function automatic logic [1:0] can_on_sleep(input logic [1:0] can_low, input logic system_error_flag);
		logic [1:0] res;
		res = can_low;
		if (can_low == 2'(BTM_XCVR_NORMAL) && !system_error_flag) begin
			res = 2'(BTM_XCVR_WAKE);
		end else if (can_low == 2'(BTM_XCVR_RX_ONLY)) begin
			res = 2'(BTM_XCVR_WAKE);
		end
		return res;
	endfunction

	// Only init and normal mode accept host writes to the peak threshold; soft reset clears it in any mode.
	function automatic logic peak_writable(input btm_chip_mode_e m);
		return (m == BTM_CHIP_INIT) || (m == BTM_CHIP_NORMAL);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register bank.

	logic [7:0] mode_ff, nxt_mode;
	logic [7:0] peak_ff, nxt_peak;
	btm_chip_mode_e chip_mode_last_ff, nxt_chip_mode_last;
	logic serr_ff, nxt_serr;

	logic enter_sleep;
	logic enter_fail;
	logic enter_restart;
	logic host_wr;

	assign enter_sleep = (chip_mode_in == BTM_CHIP_SLEEP) && (chip_mode_last_ff != BTM_CHIP_SLEEP);
	assign enter_fail = (chip_mode_in == BTM_CHIP_FAILSAFE) &&
		(chip_mode_last_ff != BTM_CHIP_FAILSAFE);
	assign enter_restart = (chip_mode_in == BTM_CHIP_RESTART) &&
		(chip_mode_last_ff != BTM_CHIP_RESTART);
	assign host_wr = frame.frame_done && frame.wr;

	always_comb begin
		nxt_mode = mode_ff;
		nxt_peak = peak_ff;
		nxt_chip_mode_last = chip_mode_in;
		// Frames of 1 to 15 bits are flagged; a refused peak write is not.
		nxt_serr = frame.frame_bad;
		// A host write is applied first, then any mode event overrides it, so
		// hardware updates are never lost to a write in the same cycle.
		if (host_wr) begin
			if (frame.addr == `BTM_ADDR_MODE) begin
				// Commit only at the end of a full frame, when chip select rises.
				nxt_mode = frame.data;
			end else if (frame.addr == `BTM_ADDR_PEAK) begin
				if (peak_writable(chip_mode_in)) begin
					nxt_peak = frame.data & `BTM_PEAK_MASK;
				end
			end
		end
		if (soft_reset_in) begin
			nxt_mode = `BTM_MODE_RESET;
			nxt_peak = `BTM_PEAK_RESET;
		end else if (enter_fail) begin
			nxt_mode[4:0] = `BTM_FAILSAFE_LOW5;
		end else if (enter_restart) begin
			nxt_mode[`BTM_LIN_HI:`BTM_LIN_LO] = restart_lin_mode_in;
			nxt_mode[`BTM_CAN_HI:`BTM_CAN_LO] = restart_can_mode_in;
			nxt_peak = peak_ff & `BTM_PEAK_MASK;
		end else if (enter_sleep) begin
			nxt_mode[`BTM_CAN_HI:`BTM_CAN_LO] =
				can_on_sleep(mode_ff[`BTM_CAN_HI:`BTM_CAN_LO], system_error_flag_in);
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode_ff <= `BTM_MODE_RESET;
			peak_ff <= `BTM_PEAK_RESET;
			chip_mode_last_ff <= BTM_CHIP_INIT;
			serr_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			peak_ff <= nxt_peak;
			chip_mode_last_ff <= nxt_chip_mode_last;
			serr_ff <= nxt_serr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	// Addresses outside this block read as zero; the rest of the chip owns them.
	always_comb begin
		if (frame.addr == `BTM_ADDR_MODE) begin
			frame.rd_data = mode_ff;
		end else if (frame.addr == `BTM_ADDR_PEAK) begin
			frame.rd_data = peak_ff & `BTM_PEAK_MASK;
		end else begin
			frame.rd_data = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transceiver control outputs.

	// The decoded controls are registered from the next register values so that
	// they track the bank in the same cycle and every output leaves a flip-flop.
	logic flash_ff, nxt_flash;
	logic lsm_ff, nxt_lsm;
	logic txto_ff, nxt_txto;
	btm_xcvr_mode_e lin_ff, nxt_lin;
	btm_xcvr_mode_e can_ff, nxt_can;
	logic swk_ff, nxt_swk;
	logic ipk_ff, nxt_ipk;

	always_comb begin
		nxt_flash = nxt_mode[`BTM_FLASH_BIT];
		nxt_lsm = nxt_mode[`BTM_LSM_BIT];
		nxt_txto = nxt_mode[`BTM_TXTO_BIT];
		nxt_lin = btm_xcvr_mode_e'(nxt_mode[`BTM_LIN_HI:`BTM_LIN_LO]);
		nxt_can = btm_xcvr_mode_e'(nxt_mode[`BTM_CAN_HI:`BTM_CAN_LO]);
		// Code 100 is off as well, so selective wake only counts with the CAN on.
		nxt_swk = nxt_mode[`BTM_SWK_BIT] && (nxt_can != BTM_XCVR_OFF);
		nxt_ipk = nxt_peak[`BTM_PEAK_BIT];
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flash_ff <= 1'b0;
			lsm_ff <= 1'b0;
			txto_ff <= 1'b1;
			lin_ff <= BTM_XCVR_OFF;
			can_ff <= BTM_XCVR_OFF;
			swk_ff <= 1'b0;
			ipk_ff <= 1'b0;
		end else begin
			flash_ff <= nxt_flash;
			lsm_ff <= nxt_lsm;
			txto_ff <= nxt_txto;
			lin_ff <= nxt_lin;
			can_ff <= nxt_can;
			swk_ff <= nxt_swk;
			ipk_ff <= nxt_ipk;
		end
	end

	assign lin_flash_out = flash_ff;
	assign low_slope_bit_out = lsm_ff;
	assign transmit_timeout_control_bit_out = txto_ff;
	assign lin_mode_out = lin_ff;
	assign can_mode_out = can_ff;
	assign selective_wake_out = swk_ff;
	assign peak_threshold_bit_out = ipk_ff;
	assign serial_error_set_out = serr_ff;
	assign sdo_out = frame.sdo;
	assign sdo_oe_n_out = frame.sdo_oe_n;
endmodule

// >>> verilog/btm_params.svh
`ifndef BTM_PARAMS_SVH
`define BTM_PARAMS_SVH

// Register addresses on the serial control port (7-bit).
`define BTM_ADDR_MODE 7'h04
`define BTM_ADDR_PEAK 7'h05

// Power-on and soft-reset values.
`define BTM_MODE_RESET 8'h20
`define BTM_PEAK_RESET 8'h00

// Low five bits forced on fail-safe entry: LIN wake capable, CAN wake capable.
`define BTM_FAILSAFE_LOW5 5'h09

// Only the peak threshold bit is implemented in the second register.
`define BTM_PEAK_MASK 8'h20

// Field positions in the mode register.
`define BTM_FLASH_BIT 7
`define BTM_LSM_BIT 6
`define BTM_TXTO_BIT 5
`define BTM_LIN_HI 4
`define BTM_LIN_LO 3
`define BTM_SWK_BIT 2
`define BTM_CAN_HI 1
`define BTM_CAN_LO 0
`define BTM_PEAK_BIT 5

// Serial frame layout: bit 0 is the write flag, bits 7:1 the address, 15:8 the data.
`define BTM_FRAME_BITS 16
`define BTM_ADDR_BYTE_BITS 8
`define BTM_WR_BIT 0

`endif

// >>> verilog/btm_pkg.sv
package btm_pkg;

	// Two-bit transceiver mode code, in code order 00, 01, 10, 11.
	typedef enum logic [1:0] {
		BTM_XCVR_OFF,
		BTM_XCVR_WAKE,
		BTM_XCVR_RX_ONLY,
		BTM_XCVR_NORMAL
	} btm_xcvr_mode_e;

	// Operating mode of the chip as reported by the chip's own mode controller.
	typedef enum logic [2:0] {
		BTM_CHIP_INIT,
		BTM_CHIP_NORMAL,
		BTM_CHIP_STOP,
		BTM_CHIP_SLEEP,
		BTM_CHIP_RESTART,
		BTM_CHIP_FAILSAFE
	} btm_chip_mode_e;

endpackage

// >>> verilog/btm_spi_frame.sv
`timescale 1ns/1ps
`include "btm_params.svh"

module btm_spi_frame #(
	parameter int FRAME_BITS = `BTM_FRAME_BITS
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic sclk_rise_in,
	input wire logic sclk_fall_in,
	input wire logic cs_active_in,
	input wire logic cs_start_in,
	input wire logic cs_end_in,
	input wire logic sdi_in,
	btm_frame_if.rx bus
);
	import btm_pkg::*;

	localparam int CW = $clog2(FRAME_BITS + 1);
	localparam logic [CW-1:0] FULL = CW'(FRAME_BITS);
	localparam logic [CW-1:0] ADDR_AT = CW'(`BTM_ADDR_BYTE_BITS);

	// The field layout is fixed, so other frame lengths are refused when elaborating.
	if (FRAME_BITS != `BTM_FRAME_BITS) begin : g_bad_frame_bits
		$error("btm_spi_frame: only 16-bit frames are served");
	end

	logic [FRAME_BITS-1:0] rx_ff, nxt_rx;
	logic [FRAME_BITS-1:0] tx_ff, nxt_tx;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic [6:0] addr_ff, nxt_addr;
	logic wr_ff, nxt_wr;
	logic [7:0] data_ff, nxt_data;
	logic ardy_ff, nxt_ardy;
	logic done_ff, nxt_done;
	logic bad_ff, nxt_bad;
	logic sdo_ff, nxt_sdo;
	logic oe_n_ff, nxt_oe_n;

	always_comb begin
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_cnt = cnt_ff;
		nxt_addr = addr_ff;
		nxt_wr = wr_ff;
		nxt_data = data_ff;
		nxt_ardy = 1'b0;
		nxt_done = 1'b0;
		nxt_bad = 1'b0;
		nxt_sdo = sdo_ff;
		nxt_oe_n = ~cs_active_in;
		if (cs_start_in) begin
			nxt_cnt = '0;
			nxt_tx = '0;
			nxt_sdo = 1'b0;
		end else if (cs_end_in) begin
			nxt_done = (cnt_ff == FULL);
			nxt_bad = (cnt_ff != FULL) && (cnt_ff != '0);
			nxt_data = rx_ff[FRAME_BITS-1:FRAME_BITS-8];
		end else if (cs_active_in) begin
			if (sclk_rise_in && cnt_ff != FULL) begin
				// Least significant bit comes first on the line.
				nxt_rx = {sdi_in, rx_ff[FRAME_BITS-1:1]};
				nxt_cnt = cnt_ff + CW'(1);
				if (nxt_cnt == ADDR_AT) begin
					nxt_addr = nxt_rx[FRAME_BITS-1:FRAME_BITS-7];
					nxt_wr = nxt_rx[FRAME_BITS-8+`BTM_WR_BIT];
					nxt_ardy = 1'b1;
				end
			end
			if (ardy_ff) begin
				// Read data goes out in the second byte, before the eighth falling edge.
				nxt_tx = {{(FRAME_BITS-8){1'b0}}, bus.rd_data};
			end else if (sclk_fall_in) begin
				nxt_sdo = tx_ff[0];
				nxt_tx = tx_ff >> 1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_ff <= '0;
			tx_ff <= '0;
			cnt_ff <= '0;
			addr_ff <= 7'h00;
			wr_ff <= 1'b0;
			data_ff <= 8'h00;
			ardy_ff <= 1'b0;
			done_ff <= 1'b0;
			bad_ff <= 1'b0;
			sdo_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			cnt_ff <= nxt_cnt;
			addr_ff <= nxt_addr;
			wr_ff <= nxt_wr;
			data_ff <= nxt_data;
			ardy_ff <= nxt_ardy;
			done_ff <= nxt_done;
			bad_ff <= nxt_bad;
			sdo_ff <= nxt_sdo;
			oe_n_ff <= nxt_oe_n;
		end
	end

	assign bus.addr = addr_ff;
	assign bus.wr = wr_ff;
	assign bus.data = data_ff;
	assign bus.addr_ready = ardy_ff;
	assign bus.frame_done = done_ff;
	assign bus.frame_bad = bad_ff;
	assign bus.sdo = sdo_ff;
	assign bus.sdo_oe_n = oe_n_ff;
endmodule
